// *** pcs_cfg.svh ***
`ifndef PCS_CFG_SVH
`define PCS_CFG_SVH
`define PCS_DIV_W 10
`define PCS_HL_W 9
`define PCS_NUM_POST 5
`define PCS_ACC_W 16
`define PCS_FREQ_RST 16'h0800
`define PCS_FREQ_STEP 16'h0008
`define PCS_FREQ_MIN 16'h0010
`define PCS_FREQ_MAX 16'h7ff0
`define PCS_CLK_PERIOD_NS 4
`define PCS_CLKBAD_NS 1000
`define PCS_CLKBAD_CYC ((`PCS_CLKBAD_NS + `PCS_CLK_PERIOD_NS - 1) / `PCS_CLK_PERIOD_NS)
`define PCS_BAD_W 12
`define PCS_ERR_W 8
`define PCS_LOCK_WIN 8'h04
`define PCS_LOCK_W 5
`define PCS_LOCK_COUNT 5'h10
`endif

// *** pcs_pkg.sv ***
`include "pcs_cfg.svh"
package pcs_pkg;
  typedef enum logic [1:0]
  {
    PCS_LK_RESET = 2'b00,
    PCS_LK_ACQ   = 2'b01,
    PCS_LK_HELD  = 2'b11
  } pcs_lock_t;

  typedef logic [`PCS_NUM_POST-1:0][`PCS_HL_W-1:0] pcs_hl_arr_t;

  typedef struct packed
  {
    logic [2:0]                                   r0_sync;
    logic [2:0]                                   r1_sync;
    logic                                         f0;
    logic                                         f1;
    logic                                         sel;
    logic                                         sw_prev;
    logic [`PCS_DIV_W-1:0]                        n_cnt;
    logic [`PCS_ACC_W-1:0]                        acc;
    logic [`PCS_ACC_W-1:0]                        freq;
    logic [`PCS_DIV_W-1:0]                        m_cnt;
    logic                                         ref_pend;
    logic                                         fb_pend;
    logic [`PCS_ERR_W-1:0]                        err_cnt;
    logic [`PCS_LOCK_W-1:0]                       lock_cnt;
    pcs_lock_t                                    lk;
    logic [`PCS_BAD_W-1:0]                        bad0;
    logic [`PCS_BAD_W-1:0]                        bad1;
    logic [1:0]                                   good;
    logic [`PCS_NUM_POST-1:0][`PCS_DIV_W-1:0]     pc_cnt;
    logic [`PCS_NUM_POST-1:0]                     pc_lvl;
    logic [`PCS_NUM_POST-1:0]                     post_clk;
    logic                                         pos;
    logic                                         neg;
    logic                                         locked;
    logic                                         active;
  } pcs_dev_st_t;

  typedef struct packed
  {
    logic                                         ref0;
    logic                                         ref1;
    logic                                         usw_prev;
    logic                                         sw_pulse;
    logic                                         rst;
    logic                                         pfd_en;
    logic [`PCS_DIV_W-1:0]                        n_div;
    logic [`PCS_DIV_W-1:0]                        m_div;
    pcs_hl_arr_t                                  hi;
    pcs_hl_arr_t                                  lo;
    logic                                         ext_en;
    logic                                         ext_diff;
    logic                                         gp_pos;
    logic                                         gp_neg;
    logic                                         locked;
    logic [1:0]                                   good;
    logic                                         active;
  } pcs_host_st_t;
endpackage

// *** pcs_link_if.sv ***
`timescale 1ns/1ps
`include "pcs_cfg.svh"
interface pcs_link_if;
  logic                  reference_input_zero;
  logic                  reference_input_one;
  logic                  switch_req;
  logic                  pll_reset;
  logic                  pfd_enable;
  logic [`PCS_DIV_W-1:0] n_div;
  logic [`PCS_DIV_W-1:0] m_div;
  pcs_pkg::pcs_hl_arr_t  post_hi;
  pcs_pkg::pcs_hl_arr_t  post_lo;
  logic                  ext_enable;
  logic                  ext_diff;
  logic                  gp_pos;
  logic                  gp_neg;
  logic [1:0]            clk_good;
  logic                  locked;
  logic                  active_clock;

  modport dev
  (
    input  reference_input_zero, reference_input_one, switch_req, pll_reset, pfd_enable,
    input  n_div, m_div, post_hi, post_lo, ext_enable, ext_diff, gp_pos, gp_neg,
    output clk_good, locked, active_clock
  );

  modport host
  (
    output reference_input_zero, reference_input_one, switch_req, pll_reset, pfd_enable,
    output n_div, m_div, post_hi, post_lo, ext_enable, ext_diff, gp_pos, gp_neg,
    input  clk_good, locked, active_clock
  );
endinterface

// *** pcs_host.sv ***
`timescale 1ns/1ps
`include "pcs_cfg.svh"
module pcs_host
(
  input  wire logic                   core_clk,
  input  wire logic                   srst,
  pcs_link_if.host                    lnk,
  input  wire logic                   user_ref0,
  input  wire logic                   user_ref1,
  input  wire logic                   user_switch,
  input  wire logic                   user_reset,
  input  wire logic                   user_pfd_en,
  input  wire logic [`PCS_DIV_W-1:0]  user_n,
  input  wire logic [`PCS_DIV_W-1:0]  user_m,
  input  wire pcs_pkg::pcs_hl_arr_t   user_hi,
  input  wire pcs_pkg::pcs_hl_arr_t   user_lo,
  input  wire logic                   user_ext_en,
  input  wire logic                   user_ext_diff,
  input  wire logic                   user_gp_pos,
  input  wire logic                   user_gp_neg,
  output logic                        user_locked,
  output logic [1:0]                  user_good,
  output logic                        user_active
);
  pcs_pkg::pcs_host_st_t q;
  pcs_pkg::pcs_host_st_t d;

  always_comb
  begin
    d = q;
    // Only clock-pin or clock-source nets belong on these user ports
    d.ref0     = user_ref0;
    d.ref1     = user_ref1;
    d.usw_prev = user_switch;
    d.sw_pulse = user_switch && !q.usw_prev;
    d.rst      = user_reset;
    d.pfd_en   = user_pfd_en;
    d.n_div    = user_n;
    d.m_div    = user_m;
    d.hi       = user_hi;
    d.lo       = user_lo;
    d.ext_en   = user_ext_en;
    d.ext_diff = user_ext_diff;
    d.gp_pos   = user_gp_pos;
    d.gp_neg   = user_gp_neg;
    d.locked   = lnk.locked;
    d.good     = lnk.clk_good;
    d.active   = lnk.active_clock;
    if (srst)
    begin
      d        = '0;
      d.rst    = 1'b1;
      d.n_div  = 10'h001;
      d.m_div  = 10'h001;
    end
  end

  always_ff @(posedge core_clk)
  begin
    q <= d;
  end

  assign lnk.reference_input_zero = q.ref0;
  assign lnk.reference_input_one  = q.ref1;
  assign lnk.switch_req           = q.sw_pulse;
  assign lnk.pll_reset            = q.rst;
  assign lnk.pfd_enable           = q.pfd_en;
  assign lnk.n_div                = q.n_div;
  assign lnk.m_div                = q.m_div;
  assign lnk.post_hi              = q.hi;
  assign lnk.post_lo              = q.lo;
  assign lnk.ext_enable           = q.ext_en;
  assign lnk.ext_diff             = q.ext_diff;
  assign lnk.gp_pos               = q.gp_pos;
  assign lnk.gp_neg               = q.gp_neg;
  assign user_locked              = q.locked;
  assign user_good                = q.good;
  assign user_active              = q.active;
endmodule

// *** pcs_dev.sv ***
`timescale 1ns/1ps
`include "pcs_cfg.svh"
module pcs_dev
#(
  parameter logic [`PCS_ACC_W-1:0] FREQ_RST  = `PCS_FREQ_RST,
  parameter logic [`PCS_ACC_W-1:0] FREQ_STEP = `PCS_FREQ_STEP
)
(
  input  wire logic                     core_clk,
  input  wire logic                     srst,
  pcs_link_if.dev                       lnk,
  output logic [`PCS_NUM_POST-1:0]      post_clk,
  output logic                          dedicated_output_pos,
  output logic                          dedicated_output_neg
);
  localparam logic [`PCS_BAD_W-1:0] BAD_CYC = `PCS_BAD_W'(`PCS_CLKBAD_CYC);

  pcs_pkg::pcs_dev_st_t q;
  pcs_pkg::pcs_dev_st_t d;

  logic                   tog0;
  logic                   tog1;
  logic                   rise0;
  logic                   rise1;
  logic                   ref_rise;
  logic                   ref_ev;
  logic                   fb_ev;
  logic                   vco_tick;
  logic [`PCS_ACC_W:0]    acc_sum;
  logic [`PCS_DIV_W-1:0]  nval;
  logic [`PCS_DIV_W-1:0]  mval;
  logic                   up;
  logic                   dn;
  logic                   resolved;
  logic [`PCS_ERR_W-1:0]  res_err;
  logic [`PCS_DIV_W-1:0]  hval;
  logic [`PCS_DIV_W-1:0]  lval;

  always_comb
  begin
    d        = q;
    up       = 1'b0;
    dn       = 1'b0;
    ref_ev   = 1'b0;
    fb_ev    = 1'b0;
    resolved = 1'b0;
    res_err  = '0;
    hval     = '0;
    lval     = '0;

    // Input qualification: third stage must agree with second before a change counts
    d.r0_sync = {q.r0_sync[1:0], lnk.reference_input_zero};
    d.r1_sync = {q.r1_sync[1:0], lnk.reference_input_one};
    tog0      = (q.r0_sync[1] == q.r0_sync[2]) && (q.r0_sync[2] != q.f0);
    tog1      = (q.r1_sync[1] == q.r1_sync[2]) && (q.r1_sync[2] != q.f1);
    rise0     = tog0 && q.r0_sync[2];
    rise1     = tog1 && q.r1_sync[2];

    // Toggle watchdogs; a stalled input reads bad after the timeout
    if (tog0)
    begin
      d.f0   = q.r0_sync[2];
      d.bad0 = '0;
    end
    else if (q.bad0 != BAD_CYC)
    begin
      d.bad0 = q.bad0 + 1'b1;
    end
    if (tog1)
    begin
      d.f1   = q.r1_sync[2];
      d.bad1 = '0;
    end
    else if (q.bad1 != BAD_CYC)
    begin
      d.bad1 = q.bad1 + 1'b1;
    end
    d.good = {q.bad1 != BAD_CYC, q.bad0 != BAD_CYC};

    // Switchover acts on the request edge so a held level swaps only once
    d.sw_prev = lnk.switch_req;
    if (lnk.switch_req && !q.sw_prev)
    begin
      d.sel = ~q.sel;
    end
    d.active = d.sel;
    ref_rise = q.sel ? rise1 : rise0;

    // Zero is taken as one so the dividers never hang
    nval = (lnk.n_div == '0) ? `PCS_DIV_W'(1) : lnk.n_div;
    mval = (lnk.m_div == '0) ? `PCS_DIV_W'(1) : lnk.m_div;

    if (ref_rise)
    begin
      if (q.n_cnt >= nval - 1'b1)
      begin
        d.n_cnt = '0;
        ref_ev  = 1'b1;
      end
      else
      begin
        d.n_cnt = q.n_cnt + 1'b1;
      end
    end

    // Oscillator: phase accumulator carry is one oscillator rising edge
    acc_sum  = {1'b0, q.acc} + {1'b0, q.freq};
    d.acc    = acc_sum[`PCS_ACC_W-1:0];
    vco_tick = acc_sum[`PCS_ACC_W];

    if (vco_tick)
    begin
      if (q.m_cnt >= mval - 1'b1)
      begin
        d.m_cnt = '0;
        fb_ev   = 1'b1;
      end
      else
      begin
        d.m_cnt = q.m_cnt + 1'b1;
      end
    end

    // Edge-only detector; whichever rising edge comes first waits for the other
    if (ref_ev && fb_ev)
    begin
      d.ref_pend = 1'b0;
      d.fb_pend  = 1'b0;
      resolved   = 1'b1;
    end
    else if (ref_ev)
    begin
      if (q.fb_pend)
      begin
        dn        = 1'b1;
        d.fb_pend = 1'b0;
        resolved  = 1'b1;
        res_err   = q.err_cnt;
      end
      else
      begin
        d.ref_pend = 1'b1;
        d.err_cnt  = '0;
      end
    end
    else if (fb_ev)
    begin
      if (q.ref_pend)
      begin
        up         = 1'b1;
        d.ref_pend = 1'b0;
        resolved   = 1'b1;
        res_err    = q.err_cnt;
      end
      else
      begin
        d.fb_pend = 1'b1;
        d.err_cnt = '0;
      end
    end
    else if ((q.ref_pend || q.fb_pend) && (q.err_cnt != '1))
    begin
      d.err_cnt = q.err_cnt + 1'b1;
    end

    // Gate holds the last frequency word, so the loop coasts
    if (lnk.pfd_enable)
    begin
      if (up && (q.freq < `PCS_FREQ_MAX))
      begin
        d.freq = q.freq + FREQ_STEP;
      end
      else if (dn && (q.freq > `PCS_FREQ_MIN))
      begin
        d.freq = q.freq - FREQ_STEP;
      end
      // Phase kick damps the loop; frequency steps alone ring and never settle
      if (up)
        d.acc = d.acc + q.freq;
      else if (dn)
        d.acc = (d.acc > q.freq) ? d.acc - q.freq : '0;
    end

    // Lock detector: consecutive small phase errors needed, one large one drops lock
    case (q.lk)
      pcs_pkg::PCS_LK_RESET:
        d.lk = pcs_pkg::PCS_LK_ACQ;
      pcs_pkg::PCS_LK_ACQ:
      begin
        if (resolved)
        begin
          if (res_err <= `PCS_LOCK_WIN)
          begin
            d.lock_cnt = q.lock_cnt + 1'b1;
            if (q.lock_cnt == `PCS_LOCK_COUNT - 1'b1)
            begin
              d.lk = pcs_pkg::PCS_LK_HELD;
            end
          end
          else
          begin
            d.lock_cnt = '0;
          end
        end
      end
      pcs_pkg::PCS_LK_HELD:
      begin
        if ((resolved && (res_err > `PCS_LOCK_WIN)) || (q.err_cnt == '1))
        begin
          d.lk       = pcs_pkg::PCS_LK_ACQ;
          d.lock_cnt = '0;
        end
      end
      default:
        d.lk = pcs_pkg::PCS_LK_RESET;
    endcase
    d.locked = (d.lk == pcs_pkg::PCS_LK_HELD);

    // Post-scale counters, all clocked by the same oscillator edge
    for (int i = 0; i < `PCS_NUM_POST; i++)
    begin
      hval = (lnk.post_hi[i] == '0) ? `PCS_DIV_W'(1) : {1'b0, lnk.post_hi[i]};
      lval = (lnk.post_lo[i] == '0) ? `PCS_DIV_W'(1) : {1'b0, lnk.post_lo[i]};
      if (vco_tick)
      begin
        if (q.pc_lvl[i] ? (q.pc_cnt[i] >= hval - 1'b1) : (q.pc_cnt[i] >= lval - 1'b1))
        begin
          d.pc_cnt[i] = '0;
          d.pc_lvl[i] = ~q.pc_lvl[i];
        end
        else
        begin
          d.pc_cnt[i] = q.pc_cnt[i] + 1'b1;
        end
      end
    end
    d.post_clk = d.pc_lvl;

    // Dedicated pair: counter zero only; free pins fall back to general-purpose data
    if (lnk.ext_enable)
    begin
      d.pos = d.pc_lvl[0];
      d.neg = lnk.ext_diff ? ~d.pc_lvl[0] : lnk.gp_neg;
    end
    else
    begin
      d.pos = lnk.gp_pos;
      d.neg = lnk.gp_neg;
    end

    // Loop reset also restarts every counter in phase
    if (srst || lnk.pll_reset)
    begin
      d        = '0;
      d.freq   = FREQ_RST;
      d.pc_lvl   = '1;
      d.post_clk = '1;
      d.good   = 2'h3;
      d.lk     = pcs_pkg::PCS_LK_RESET;
    end
  end

  always_ff @(posedge core_clk)
  begin
    q <= d;
  end

  assign lnk.clk_good         = q.good;
  assign lnk.locked           = q.locked;
  assign lnk.active_clock     = q.active;
  assign post_clk             = q.post_clk;
  assign dedicated_output_pos = q.pos;
  assign dedicated_output_neg = q.neg;
endmodule

// *** pcs_link_assertions.sv ***
`timescale 1ns/1ps
module pcs_link_assertions
(
  input wire logic       core_clk,
  input wire logic       srst,
  input wire logic       reference_input_zero,
  input wire logic       reference_input_one,
  input wire logic       switch_req,
  input wire logic       pll_reset,
  input wire logic [1:0] clk_good,
  input wire logic       locked,
  input wire logic       active_clock
);
  logic [8:0] idle_q;
  logic [4:0] rise_q;
  logic       r0_q;
  logic       r1_q;

  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  // Restarted with the loop so the bounds line up with the device watchdog
  always_ff @(posedge core_clk)
  begin
    r0_q <= reference_input_zero;
    r1_q <= reference_input_one;
    if (srst || pll_reset || r1_q != reference_input_one)
      idle_q <= 9'h000;
    else if (idle_q != 9'h1ff)
      idle_q <= idle_q + 9'h001;
    if (srst || pll_reset)
      rise_q <= 5'h00;
    else if (rise_q != 5'h1f && ((reference_input_zero && !r0_q) || (reference_input_one && !r1_q)))
      rise_q <= rise_q + 5'h01;
  end

  AST_RST_LOCK: assert property (pll_reset |=> !locked)
    else $error("lock high after loop reset");
  AST_RST_STAT: assert property (pll_reset |=> clk_good == 2'b11 && !active_clock)
    else $error("status not cleared by loop reset");
  AST_LOCK_EARLY: assert property ($rose(locked) |-> rise_q >= 5'h10)
    else $error("lock before enough reference edges");
  AST_SW_FLIP: assert property ($rose(switch_req) && !pll_reset |=> active_clock != $past(active_clock))
    else $error("switch request did not swap input");
  AST_ACT_HOLD: assert property (!$rose(switch_req) && !pll_reset |=> $stable(active_clock))
    else $error("active input changed without request");
  AST_SW_PULSE: assert property (switch_req |=> !switch_req)
    else $error("switch request longer than one cycle");
  AST_GOOD_BACK: assert property ($changed(reference_input_one) |-> ##[1:8] clk_good[1])
    else $error("toggling input not reported good");
  AST_GOOD_DROP: assert property ($fell(clk_good[1]) |-> idle_q >= 9'h0fa)
    else $error("input reported bad too early");
  AST_GOOD_LATE: assert property (idle_q >= 9'h12c |-> !clk_good[1])
    else $error("stopped input still reported good");

  cover property ($rose(locked));
  cover property ($fell(clk_good[1]));
  cover property ($rose(switch_req) ##1 active_clock);
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic                 core_clk = 1'b0;
  logic                 srst = 1'b1;
  logic                 ref0 = 1'b0;
  logic                 ref1 = 1'b0;
  logic                 usw = 1'b0;
  logic                 urst = 1'b0;
  logic                 upfd = 1'b1;
  logic                 uext = 1'b0;
  logic                 udiff = 1'b0;
  logic                 gpp = 1'b1;
  logic                 gpn = 1'b0;
  logic [9:0]           un = 10'h002;
  logic [9:0]           um = 10'h008;
  pcs_pkg::pcs_hl_arr_t hi = {9'h004, 9'h003, 9'h001, 9'h002, 9'h001};
  pcs_pkg::pcs_hl_arr_t lo = {9'h004, 9'h002, 9'h003, 9'h002, 9'h001};
  logic                 lck;
  logic [1:0]           good;
  logic                 act;
  logic [4:0]           post;
  logic [4:0]           post_q;
  logic                 dpos;
  logic                 dneg;
  int                   half0 = 32;
  int                   half1 = 0;
  int                   c0n = 0;
  int                   c1n = 0;
  int                   ticks = 0;
  int                   rises [5];
  int                   divs [5] = '{2, 4, 4, 5, 8};
  int                   n_mismatch = 0;
  int                   cmp_count = 0;

  pcs_link_if lnk ();
  pcs_host u_pcs_host (.core_clk(core_clk), .srst(srst), .lnk(lnk), .user_ref0(ref0), .user_ref1(ref1),
    .user_switch(usw), .user_reset(urst), .user_pfd_en(upfd), .user_n(un), .user_m(um), .user_hi(hi),
    .user_lo(lo), .user_ext_en(uext), .user_ext_diff(udiff), .user_gp_pos(gpp), .user_gp_neg(gpn),
    .user_locked(lck), .user_good(good), .user_active(act));
  pcs_dev #(.FREQ_RST(16'h0e00), .FREQ_STEP(16'h0020)) u_pcs_dev (.core_clk(core_clk), .srst(srst),
    .lnk(lnk), .post_clk(post), .dedicated_output_pos(dpos), .dedicated_output_neg(dneg));
  pcs_link_assertions u_pcs_link_assertions (.core_clk(core_clk), .srst(srst),
    .reference_input_zero(lnk.reference_input_zero), .reference_input_one(lnk.reference_input_one),
    .switch_req(lnk.switch_req), .pll_reset(lnk.pll_reset), .clk_good(lnk.clk_good),
    .locked(lnk.locked), .active_clock(lnk.active_clock));

  always #2 core_clk = ~core_clk;

  // Clean generated references only, never logic-derived; slow so ticks stay below the core rate
  always @(posedge core_clk)
  begin
    #1;
    c0n++;
    c1n++;
    if (c0n >= half0)
    begin
      ref0 = ~ref0;
      c0n = 0;
    end
    if (half1 != 0 && c1n >= half1)
    begin
      ref1 = ~ref1;
      c1n = 0;
    end
  end

  // Counter zero runs at divide two, so each of its edges is one oscillator tick
  always @(negedge core_clk)
  begin
    post_q <= post;
    if (post[0] !== post_q[0])
      ticks++;
    foreach (rises[i])
      if (post[i] === 1'b1 && post_q[i] === 1'b0)
        rises[i]++;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ok(input logic c);
    chk({31'h0, c}, 32'h1);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic measure;
    ticks = 0;
    foreach (rises[i])
      rises[i] = 0;
    cyc(1024);
  endtask

  task automatic wait_lock;
    int k = 0;
    while (lck !== 1'b1 && k < 25000)
    begin
      cyc(1);
      k++;
    end
    ok(lck === 1'b1);
  endtask

  task automatic done(input string s);
    $display("test %s finished, %0d checks so far", s, cmp_count);
  endtask

  initial
  begin
    #360000;
    n_mismatch++;
    give_verdict;
  end

  initial
  begin
    logic pin_ok;
    cyc(4);
    srst = 1'b0;
    cyc(3);
    chk(32'(lck), 32'h0);
    wait_lock;
    done("boot");
    // Ref event every 128 cycles, m of 8: 64 ticks per 1024 cycles
    measure;
    ok(ticks >= 60 && ticks <= 68);
    foreach (divs[i])
      ok(rises[i] * divs[i] >= ticks - divs[i] && rises[i] * divs[i] <= ticks + divs[i]);
    done("ratio");
    upfd = 1'b0;
    half0 = 24;
    cyc(2048);
    measure;
    ok(ticks >= 60 && ticks <= 68);
    upfd = 1'b1;
    // Long settle: the loop slews one step per comparison, then rings down
    cyc(12000);
    measure;
    ok(ticks >= 78);
    half0 = 32;
    cyc(12000);
    measure;
    ok(ticks >= 60 && ticks <= 68);
    done("loop");
    chk(32'(good), 32'h1);
    half1 = 20;
    cyc(40);
    chk(32'(lnk.clk_good), 32'h3);
    half1 = 0;
    cyc(300);
    chk(32'(good), 32'h1);
    done("status");
    for (int md = 0; md < 3; md++)
    begin
      uext = md > 0;
      udiff = md > 1;
      gpn = md == 1;
      cyc(4);
      repeat (64)
      begin
        cyc(1);
        pin_ok = (md == 0) ? (dpos === 1'b1) : (dpos === post[0] || dpos === post_q[0]);
        pin_ok &= (md == 2) ? (dneg === ~dpos) : (dneg === gpn);
        ok(pin_ok);
      end
    end
    done("pins");
    usw = 1'b1;
    cyc(3);
    chk(32'(act), 32'h1);
    cyc(10);
    chk(32'(lnk.active_clock), 32'h1);
    usw = 1'b0;
    done("switch");
    urst = 1'b1;
    cyc(4);
    chk(32'(lck), 32'h0);
    chk(32'(act), 32'h0);
    chk(32'(post), 32'h1f);
    urst = 1'b0;
    cyc(20);
    chk(32'(lck), 32'h0);
    wait_lock;
    done("reset");
    give_verdict;
  end
endmodule
